// file: idbm_decode.sv
// instruction register, its partial decodes, prefetch qualifiers and branch test mux
// Functional notes
// - seven muxes: two on bit 0, five on 1-5
// - first dispatch test feeds every affected bit
// - bit1 16-input, bits2-3 8-input, upper 4-input
// - low-true decode of tests 37..34, test point
// - tests 30..37 decode enables muxes, flag clocks
// - bits 5..1 each one OR input
// - bit 0 split 37-20 and 17-00, no expansion
// - expansion code ORed into bits 5..1
// - 16-bit instruction register loads from d selector
// - all sixteen register bits exported
// - low source/destination fields drive register select
// - low-true decode of bits 14..12 zero
// - low-true source mode decodes 0,1,2,3,7
// - low-true decodes bits 8..6 equal 6, 0
// - low-true decode destination mode zero
// - low-true decode bits 2..0 equal 6
// - register clear held inactive permanently
// - prefetch cycle covers instruction plus jump cases
// - service requests inhibit prefetch cycle only through its instruction term
// - prefetch instruction for mode-zero operand forms
// - prefetch instruction suppressed by listed exceptions
// - prefetch instruction feeds status prefetch flag
module idbm_decode (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [idbm_pkg::IDBM_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// microword and data path
	input wire logic [idbm_pkg::IDBM_BF_W-1:0] i_microbranch_select_field,
	input wire logic i_instr_reg_load_enable,
	input wire logic [idbm_pkg::IDBM_IR_W-1:0] i_d_selector,
	input wire logic [idbm_pkg::IDBM_NUM_TESTS-1:0][idbm_pkg::IDBM_CODE_W-1:0] i_test_codes,
	input wire logic [idbm_pkg::IDBM_CODE_W-1:1] i_exp_branch_code,
	// prefetch exception inputs
	input wire logic i_pc_changing,
	input wire logic i_bus_request,
	input wire logic i_power_fail,
	input wire logic i_console_halt,
	input wire logic i_trace_bit,
	// branch code to the next-address gate
	output logic [idbm_pkg::IDBM_CODE_W-1:1] o_basic_branch_code,
	output logic o_branch_code0_upper,
	output logic o_branch_code0_lower,
	output logic o_upper_test_group_decode,
	output logic o_tests_37_34_n,
	// instruction register and decodes
	output logic [idbm_pkg::IDBM_IR_W-1:0] o_instruction_register,
	output logic [2:0] o_src_reg_select,
	output logic [2:0] o_dst_reg_select,
	output logic o_ir_14_12_zero_n,
	output logic [4:0] o_source_mode_field_n,
	output logic o_ir_8_6_eq6_n,
	output logic o_ir_8_6_zero_n,
	output logic o_dest_mode_field_zero_n,
	output logic o_ir_2_0_eq6_n,
	output logic o_prefetch_cycle,
	output logic o_prefetch_instruction
);
	timeunit 1ns;
	timeprecision 1ps;
	import idbm_pkg::*;

	logic rst_meta_q; // first reset stage, read only by the second
	logic rst_sync_q; // released reset used everywhere else
	logic [15:0] ir_q; // instruction register
	logic [15:0] ir_d; // its next value
	logic [31:0] ctrl_q; // control register
	logic exp_en; // expansion merge enable
	logic upper_grp; // tests 30..37 selected
	logic t34_37; // tests 34..37 selected
	logic [5:0] code_sel; // selected code per microaddress bit
	logic code0_lower; // bit 0 code for tests 17..01
	logic [5:0] exp_code; // expansion code aligned to microaddress bits, bit 0 unused
	logic [2:0] smode_d; // next source mode
	logic [2:0] dmode_d; // next destination mode
	logic [2:0] src_d; // next source register field
	logic [2:0] dst_d; // next destination register field
	logic single_op; // single operand group
	logic double_op; // double operand group
	logic jump_like; // jump or subroutine jump
	logic pf_instr; // prefetch instruction, combinational
	logic pf_cycle; // prefetch cycle, combinational
	logic apb_access; // access phase with no answer yet
	logic apb_hit; // address decodes to a register
	logic [31:0] rd_mux; // read data for the current address
	logic [7:0] decodes_n; // registered low-true decodes for status readback

	// two-stage reset release
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// next instruction register value, loaded only on the microword strobe
	always_comb begin
		ir_d = ir_q;
		if (i_instr_reg_load_enable) begin
			ir_d = i_d_selector;
		end
	end

	// instruction register; its clear input is held inactive, so only reset clears it
	always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ir_q <= IDBM_IR_RST;
		end else begin
			ir_q <= ir_d;
		end
	end

	// field extraction from the next value keeps decodes aligned with the register
	always_comb begin
		smode_d = ir_d[IDBM_SMODE_LSB +: 3];
		dmode_d = ir_d[IDBM_DMODE_LSB +: 3];
		src_d = ir_d[IDBM_SRC_LSB +: 3];
		dst_d = ir_d[IDBM_DST_LSB +: 3];
	end

	// instruction class recognition for the prefetch terms
	always_comb begin
		double_op = (ir_d[IDBM_OP_LSB +: 3] != IDBM_VAL_0) && (ir_d[IDBM_OP_LSB +: 3] != IDBM_VAL_7);
		single_op = (ir_d[IDBM_OP_LSB +: 3] == IDBM_VAL_0) && (smode_d == IDBM_VAL_0)
			&& ((src_d == IDBM_VAL_5) || (src_d == IDBM_VAL_6));
		jump_like = (ir_d[15:6] == IDBM_JUMP_OP) || (ir_d[15:9] == IDBM_SUBJ_OP);
	end

	// prefetch qualifiers
	always_comb begin
		pf_instr = (single_op && (dmode_d == IDBM_VAL_0))
			|| (double_op && (smode_d == IDBM_VAL_0) && (dmode_d == IDBM_VAL_0));
		// any exception vetoes the instruction overlap
		if ((dst_d == IDBM_VAL_7) || i_pc_changing || i_bus_request || i_power_fail
			|| i_console_halt || i_trace_bit || (ir_d[15:12] == IDBM_MOVB_OP)) begin
			pf_instr = 1'b0;
		end
		// service requests are deliberately absent from the extra cycle terms
		pf_cycle = pf_instr
			|| (jump_like && (dmode_d >= IDBM_VAL_6))
			|| (double_op && (smode_d == IDBM_VAL_0) && (dmode_d >= IDBM_VAL_6))
			|| (double_op && (smode_d >= IDBM_VAL_6));
	end

	// decodes, register selects and prefetch outputs, all from flops
	always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			o_instruction_register <= IDBM_IR_RST;
			o_src_reg_select <= IDBM_VAL_0;
			o_dst_reg_select <= IDBM_VAL_0;
			o_ir_14_12_zero_n <= 1'b1;
			o_source_mode_field_n <= 5'h1F;
			o_ir_8_6_eq6_n <= 1'b1;
			o_ir_8_6_zero_n <= 1'b1;
			o_dest_mode_field_zero_n <= 1'b1;
			o_ir_2_0_eq6_n <= 1'b1;
			o_prefetch_cycle <= 1'b0;
			o_prefetch_instruction <= 1'b0;
		end else begin
			o_instruction_register <= ir_d;
			o_src_reg_select <= src_d;
			o_dst_reg_select <= dst_d;
			o_ir_14_12_zero_n <= ~(ir_d[IDBM_OP_LSB +: 3] == IDBM_VAL_0);
			// index 0..4: mode 0, 1, 2, 3, 7
			o_source_mode_field_n <= ~{smode_d == IDBM_VAL_7, smode_d == IDBM_VAL_3,
				smode_d == IDBM_VAL_2, smode_d == IDBM_VAL_1, smode_d == IDBM_VAL_0};
			o_ir_8_6_eq6_n <= ~(src_d == IDBM_VAL_6);
			o_ir_8_6_zero_n <= ~(src_d == IDBM_VAL_0);
			o_dest_mode_field_zero_n <= ~(dmode_d == IDBM_VAL_0);
			o_ir_2_0_eq6_n <= ~(dst_d == IDBM_VAL_6);
			o_prefetch_cycle <= pf_cycle;
			o_prefetch_instruction <= pf_instr;
		end
	end

	// branch field group decodes
	always_comb begin
		upper_grp = (i_microbranch_select_field[4:3] == IDBM_UPPER_GRP);
		t34_37 = (i_microbranch_select_field[4:2] == IDBM_T34_37);
		exp_en = ctrl_q[IDBM_CTRL_EXP_EN_BIT];
		// bit 0 slot stays zero so no constant index falls outside the expansion port
		exp_code = {i_exp_branch_code, 1'b0};
	end

	// one mux per microaddress bit; its reach is the span of tests touching that bit
	genvar gb;
	generate
		for (gb = 0; gb < IDBM_CODE_W; gb++) begin : g_bit
			always_comb begin
				code_sel[gb] = 1'b0;
				// bits 2..5 only see the upper group, which enables their muxes
				if ((i_microbranch_select_field >= IDBM_MUX_BASE[gb*5 +: 5])
					&& ((gb < 2) || upper_grp)) begin
					code_sel[gb] = i_test_codes[i_microbranch_select_field][gb];
				end
				// expansion code joins bits 5..1 whenever a test is called
				if ((gb > 0) && exp_en && (i_microbranch_select_field != IDBM_TEST_NONE)) begin
					code_sel[gb] = code_sel[gb] | exp_code[gb];
				end
			end
		end
	endgenerate

	// second bit 0 mux for the low tests; test 00 means no branch
	always_comb begin
		code0_lower = 1'b0;
		if ((i_microbranch_select_field < IDBM_TEST_20)
			&& (i_microbranch_select_field != IDBM_TEST_NONE)) begin
			code0_lower = i_test_codes[i_microbranch_select_field][0];
		end
	end

	// branch code outputs registered for the next-address gate
	always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			o_basic_branch_code <= 5'h00;
			o_branch_code0_upper <= 1'b0;
			o_branch_code0_lower <= 1'b0;
			o_upper_test_group_decode <= 1'b0;
			o_tests_37_34_n <= 1'b1;
		end else begin
			o_basic_branch_code <= code_sel[5:1];
			o_branch_code0_upper <= code_sel[0];
			o_branch_code0_lower <= code0_lower;
			o_upper_test_group_decode <= upper_grp;
			o_tests_37_34_n <= ~t34_37;
		end
	end

	// status copy of eight low-true decodes; bits 14..12 zero and source mode 7 are not copied
	always_comb begin
		decodes_n = {o_ir_2_0_eq6_n, o_dest_mode_field_zero_n, o_ir_8_6_zero_n, o_ir_8_6_eq6_n,
			o_source_mode_field_n[3:0]};
	end

	// apb: one wait state, every access answered on its second access cycle
	always_comb begin
		apb_access = i_psel && i_penable && !o_pready;
		apb_hit = (i_paddr == IDBM_REG_CTRL_OFS) || (i_paddr == IDBM_REG_IR_OFS)
			|| (i_paddr == IDBM_REG_STAT_OFS);
		rd_mux = 32'h0000_0000;
		// address decode
		if (i_paddr == IDBM_REG_CTRL_OFS) begin
			rd_mux = ctrl_q;
		end else if (i_paddr == IDBM_REG_IR_OFS) begin
			rd_mux = {16'h0000, o_instruction_register};
		end else if (i_paddr == IDBM_REG_STAT_OFS) begin
			rd_mux[IDBM_STAT_UPPER_GRP_BIT] = o_upper_test_group_decode;
			rd_mux[IDBM_STAT_T34_37_N_BIT] = o_tests_37_34_n;
			rd_mux[IDBM_STAT_PF_INSTR_BIT] = o_prefetch_instruction;
			rd_mux[IDBM_STAT_PF_CYCLE_BIT] = o_prefetch_cycle;
			rd_mux[IDBM_STAT_DECODE_LSB +: 8] = decodes_n;
		end
	end

	// control register; read-only and unmapped writes are dropped
	always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ctrl_q <= IDBM_CTRL_RST;
		end else if (apb_access && i_pwrite && (i_paddr == IDBM_REG_CTRL_OFS)) begin
			ctrl_q <= {31'h0000_0000, i_pwdata[IDBM_CTRL_EXP_EN_BIT]};
		end
	end

	// apb answer flops
	always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			o_pready <= apb_access;
			o_pslverr <= apb_access && !apb_hit;
			o_prdata <= (apb_access && !i_pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// checks
	AST_IR_LOAD: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		i_instr_reg_load_enable |=> (o_instruction_register == $past(i_d_selector)))
		else $error("instruction register did not take d selector");
	AST_IR_HOLD: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		!i_instr_reg_load_enable |=> $stable(o_instruction_register))
		else $error("instruction register changed without load");
	AST_NO_TEST: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		(i_microbranch_select_field == IDBM_TEST_NONE) |=> ((o_basic_branch_code == 5'h00)
		&& !o_branch_code0_upper && !o_branch_code0_lower))
		else $error("branch code active with no test");
	AST_T34: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		(i_microbranch_select_field[4:2] == IDBM_T34_37) |=> !o_tests_37_34_n)
		else $error("tests 37..34 decode missing");
	AST_GRP: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		!upper_grp && !(exp_en && (i_exp_branch_code[5:2] != 4'h0))
		|=> (!o_upper_test_group_decode && (o_basic_branch_code[5:2] == 4'h0)))
		else $error("upper mux active outside tests 30..37");
	AST_BIT0_SPLIT: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		##1 !(o_branch_code0_upper && o_branch_code0_lower))
		else $error("both bit 0 codes active together");
	AST_DISPATCH: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		(i_microbranch_select_field == 5'h1F) && !exp_en |=> ({o_basic_branch_code,
		o_branch_code0_upper} == $past(i_test_codes[31])))
		else $error("first dispatch code not passed on all bits");
	AST_PF_SUPP: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		(i_bus_request || i_power_fail || i_console_halt || i_trace_bit || i_pc_changing)
		|=> !o_prefetch_instruction)
		else $error("prefetch instruction during exception");
	AST_PF_CYC: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		o_prefetch_instruction |-> o_prefetch_cycle)
		else $error("prefetch cycle missing with prefetch instruction");
	AST_DM0: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		rst_sync_q |=> (o_dest_mode_field_zero_n == (o_instruction_register[5:3] != IDBM_VAL_0)))
		else $error("destination mode zero decode wrong");
	// decode and veto checks that the bench stimulus reaches
	AST_BIT0_UPPER_ONLY: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		(i_microbranch_select_field < IDBM_TEST_20) |=> !o_branch_code0_upper)
		else $error("upper bit 0 code active for a low test");
	AST_REG_SEL: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		i_instr_reg_load_enable |=> ((o_src_reg_select == $past(i_d_selector[8:6]))
		&& (o_dst_reg_select == $past(i_d_selector[2:0]))))
		else $error("register select fields do not follow the load");
	AST_PF_MOVB: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		(ir_d[15:12] == IDBM_MOVB_OP) |=> !o_prefetch_instruction)
		else $error("prefetch instruction for a byte move");
	AST_GRP_SET: assert property (@(posedge i_sys_clk) disable iff (!rst_sync_q)
		upper_grp |=> o_upper_test_group_decode)
		else $error("upper test group decode missing");
endmodule : idbm_decode

// file: idbm_far_model.sv
// far-side model: microsequencer microword fields and the status prefetch flag
module idbm_far_model (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [4:0] i_req_field,
	input wire logic i_req_load,
	input wire logic i_prefetch_instruction,
	output logic [4:0] o_microbranch_select_field,
	output logic o_instr_reg_load_enable,
	output logic o_prefetch_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// microword fields pass straight through from the sequencer step
	assign o_microbranch_select_field = i_req_field;
	assign o_instr_reg_load_enable = i_req_load;
	// prefetch flag samples the decode every cycle, cleared by reset
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_prefetch_flag <= 1'b0;
		end else begin
			o_prefetch_flag <= i_prefetch_instruction;
		end
	end
endmodule : idbm_far_model

// file: idbm_pkg.sv
// constants shared by the instruction decode and branch mux block
package idbm_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	// apb register map (byte addresses)
	localparam int IDBM_ADDR_W = 12; // apb address width
	localparam logic [11:0] IDBM_REG_CTRL_OFS = 12'h000; // control, read/write
	localparam logic [11:0] IDBM_REG_IR_OFS = 12'h004; // instruction register copy, read only
	localparam logic [11:0] IDBM_REG_STAT_OFS = 12'h008; // decode and prefetch status, read only
	// control register fields
	localparam int IDBM_CTRL_EXP_EN_BIT = 0; // merge expansion branch code
	localparam logic [31:0] IDBM_CTRL_RST = 32'h0000_0001; // expansion merge on after reset
	// status register fields
	localparam int IDBM_STAT_UPPER_GRP_BIT = 0; // upper test group decode
	localparam int IDBM_STAT_T34_37_N_BIT = 1; // tests 37..34 decode, low true
	localparam int IDBM_STAT_PF_INSTR_BIT = 2; // prefetch instruction
	localparam int IDBM_STAT_PF_CYCLE_BIT = 3; // prefetch cycle
	localparam int IDBM_STAT_DECODE_LSB = 4; // eight low-true ir decodes start here
	// instruction register
	localparam int IDBM_IR_W = 16; // instruction register width
	localparam logic [15:0] IDBM_IR_RST = 16'h0000; // instruction register reset value
	localparam int IDBM_SMODE_LSB = 9; // source mode, bits 11:9
	localparam int IDBM_SRC_LSB = 6; // source register, bits 8:6
	localparam int IDBM_DMODE_LSB = 3; // destination mode, bits 5:3
	localparam int IDBM_DST_LSB = 0; // destination register, bits 2:0
	localparam int IDBM_OP_LSB = 12; // operation group, bits 14:12
	// branch test selection
	localparam int IDBM_BF_W = 5; // microbranch select field width (tests 00..37 octal)
	localparam int IDBM_NUM_TESTS = 32; // number of branch tests
	localparam int IDBM_CODE_W = 6; // branch code bits 5..0
	localparam logic [4:0] IDBM_TEST_NONE = 5'h00; // test 00 selects no branch
	localparam logic [4:0] IDBM_TEST_20 = 5'h10; // first test of the upper bit 0 group
	localparam logic [1:0] IDBM_UPPER_GRP = 2'h3; // tests 30..37 share field bits 4:3
	localparam logic [2:0] IDBM_T34_37 = 3'h7; // tests 34..37 share field bits 4:2
	// lowest test reaching each microaddress bit, bit 5 leftmost
	localparam logic [29:0] IDBM_MUX_BASE = {5'h1C, 5'h1C, 5'h18, 5'h18, 5'h10, 5'h10};
	// mode and register values
	localparam logic [2:0] IDBM_VAL_0 = 3'h0; // mode or register zero
	localparam logic [2:0] IDBM_VAL_1 = 3'h1; // mode one
	localparam logic [2:0] IDBM_VAL_2 = 3'h2; // mode two
	localparam logic [2:0] IDBM_VAL_3 = 3'h3; // mode three
	localparam logic [2:0] IDBM_VAL_5 = 3'h5; // single operand group 005x
	localparam logic [2:0] IDBM_VAL_6 = 3'h6; // mode six
	localparam logic [2:0] IDBM_VAL_7 = 3'h7; // mode seven, register 07
	localparam logic [9:0] IDBM_JUMP_OP = 10'h001; // jump, bits 15:6
	localparam logic [6:0] IDBM_SUBJ_OP = 7'h04; // subroutine jump, bits 15:9
	localparam logic [3:0] IDBM_MOVB_OP = 4'h9; // byte move, bits 15:12
endpackage : idbm_pkg

// file: tb_instr_decode_branch_mux.sv
// self-checking bench for the instruction decode and branch mux block
module tb_instr_decode_branch_mux;
	timeunit 1ns;
	timeprecision 1ps;
	import idbm_pkg::*;
	// fixed instructions for the prefetch cases
	localparam logic [15:0] IR_LIST [10] = '{16'h0A00, 16'h0A07, 16'h0A08, 16'h1042,
		16'h9042, 16'h0071, 16'h0977, 16'h1031, 16'h1C42, 16'h6E42};
	logic clk, rst_n, psel, pen, pwr, pready, pslverr, e, ld, ldm;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] field, fieldm, smode_n;
	logic [15:0] dsel, ir;
	logic [31:0][5:0] codes;
	logic [5:1] expc, bbc;
	logic pcc, breq, pfail, halt, trc, c0u, c0l, ugrp, t_n, z1412_n;
	logic eq86_n, z86_n, dmode0_n, eq20_n, pfc, pfi, flag;
	logic [2:0] srs, dss;
	int err_total, checked;
	idbm_far_model i_idbm_far_model (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req_field(field),
		.i_req_load(ld), .i_prefetch_instruction(pfi), .o_microbranch_select_field(fieldm),
		.o_instr_reg_load_enable(ldm), .o_prefetch_flag(flag));
	idbm_decode i_idbm_decode (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_microbranch_select_field(fieldm), .i_instr_reg_load_enable(ldm),
		.i_d_selector(dsel), .i_test_codes(codes), .i_exp_branch_code(expc),
		.i_pc_changing(pcc), .i_bus_request(breq), .i_power_fail(pfail),
		.i_console_halt(halt), .i_trace_bit(trc), .o_basic_branch_code(bbc),
		.o_branch_code0_upper(c0u), .o_branch_code0_lower(c0l),
		.o_upper_test_group_decode(ugrp), .o_tests_37_34_n(t_n),
		.o_instruction_register(ir), .o_src_reg_select(srs), .o_dst_reg_select(dss),
		.o_ir_14_12_zero_n(z1412_n), .o_source_mode_field_n(smode_n),
		.o_ir_8_6_eq6_n(eq86_n), .o_ir_8_6_zero_n(z86_n),
		.o_dest_mode_field_zero_n(dmode0_n), .o_ir_2_0_eq6_n(eq20_n),
		.o_prefetch_cycle(pfc), .o_prefetch_instruction(pfi));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; waits on pready with a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(pready, 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	// own prefetch reckoning: {cycle, instruction}
	function automatic logic [1:0] pf_exp(input logic [15:0] d, input logic [4:0] v);
		logic dop, sop, jump, ins;
		dop = d[14:12] != 3'h0 && d[14:12] != 3'h7;
		sop = d[14:9] == 6'h00 && (d[8:6] == 3'h5 || d[8:6] == 3'h6);
		jump = d[15:6] == 10'h001 || d[15:9] == 7'h04;
		ins = (sop || (dop && d[11:9] == 3'h0)) && d[5:3] == 3'h0 && d[2:0] != 3'h7;
		ins = ins && v == 5'h00 && d[15:12] != 4'h9;
		return {ins || (jump && d[5:4] == 2'h3) || (dop && ((d[11:9] == 3'h0 && d[5:4] == 2'h3)
			|| d[11:10] == 2'h3)), ins};
	endfunction : pf_exp
	// reset values, masked bits, read-only and unmapped places
	task automatic t_regs();
		apb(1'b0, IDBM_REG_CTRL_OFS, 32'h0, rd, e);
		chk(rd, IDBM_CTRL_RST);
		apb(1'b1, IDBM_REG_CTRL_OFS, 32'hFFFF_FFFE, rd, e);
		apb(1'b0, IDBM_REG_CTRL_OFS, 32'h0, rd, e);
		chk(rd, 32'h0);
		apb(1'b1, IDBM_REG_IR_OFS, 32'hFFFF_FFFF, rd, e);
		apb(1'b0, IDBM_REG_IR_OFS, 32'h0, rd, e);
		chk({e, rd[30:0]}, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0, rd, e);
		chk({e, rd[30:0]}, 32'h8000_0000);
	endtask : t_regs
	// every test number, expansion merge off then on
	task automatic t_branch();
		logic [5:0] m;
		for (int t = 0; t < 32; t++) codes[t] <= 6'(t * 5 + 11);
		for (int en = 0; en < 2; en++) begin
			apb(1'b1, IDBM_REG_CTRL_OFS, 32'(en), rd, e);
			for (int f = 0; f < 32; f++) begin
				@(posedge clk);
				field <= 5'(f);
				expc <= 5'(~f);
				repeat (2) @(posedge clk);
				#1;
				m = {f >= 28, f >= 28, f >= 24, f >= 24, f >= 16, 1'b0};
				// merge only when a test is selected
				chk(bbc, (codes[f][5:1] & m[5:1]) | ((en && f) ? 5'(~f) : 5'h00));
				chk(c0u, codes[f][0] & (f >= 16));
				chk(c0l, codes[f][0] & (f >= 1) & (f < 16));
				chk(ugrp, f >= 24);
				chk(t_n, f < 28);
			end
		end
	endtask : t_branch
	// loads, field decodes and prefetch under each veto
	task automatic t_ir();
		logic [15:0] d;
		logic [4:0] v;
		logic [1:0] p;
		for (int i = 0; i < 18; i++) begin
			d = (i < 8) ? 16'(i * 'h9249) : IR_LIST[i - 8];
			for (int j = 0; j < 6; j++) begin
				v = 5'((1 << j) >> 1);
				p = pf_exp(d, v);
				@(posedge clk);
				dsel <= d;
				ld <= 1'b1;
				{trc, halt, pfail, breq, pcc} <= v;
				repeat (2) @(posedge clk);
				#1;
				chk(ir, d);
				chk({srs, dss}, {d[8:6], d[2:0]});
				chk(z1412_n, d[14:12] != 3'h0);
				chk(smode_n, {d[11:9] != 3'h7, d[11:9] != 3'h3, d[11:9] != 3'h2,
					d[11:9] != 3'h1, d[11:9] != 3'h0});
				chk({eq86_n, z86_n}, {d[8:6] != 3'h6, d[8:6] != 3'h0});
				chk(dmode0_n, d[5:3] != 3'h0);
				chk(eq20_n, d[2:0] != 3'h6);
				chk({pfc, pfi}, p);
				chk(flag, p[0]);
				// status readback: field still selects test 37
				apb(1'b0, IDBM_REG_STAT_OFS, 32'h0, rd, e);
				chk({e, rd[30:0]}, {20'h0, d[2:0] != 3'h6, d[5:3] != 3'h0, d[8:6] != 3'h0,
					d[8:6] != 3'h6, d[11:9] != 3'h3, d[11:9] != 3'h2, d[11:9] != 3'h1,
					d[11:9] != 3'h0, p, 2'b01});
			end
		end
		// with the load bit low the register must hold
		@(posedge clk);
		ld <= 1'b0;
		dsel <= ~d;
		repeat (3) @(posedge clk);
		#1;
		chk(ir, d);
		// a bus write to the read-only copy must leave the register alone
		apb(1'b1, IDBM_REG_IR_OFS, {16'h0, ~d}, rd, e);
		chk(e, 1'b0);
		apb(1'b0, IDBM_REG_IR_OFS, 32'h0, rd, e);
		chk(rd, {16'h0, d});
	endtask : t_ir
	// verdict and end of run
	task automatic print_verdict();
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// main sequence
	initial begin
		{rst_n, psel, pen, pwr, ld, pcc, breq, pfail, halt, trc} = '0;
		{paddr, pwdata, field, dsel, codes, expc} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_branch();
		t_ir();
		print_verdict();
	end
	// hang guard, about ten times the thousand or so cycles needed
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
endmodule : tb_instr_decode_branch_mux
